// [hw/adc_ctrl_pkg.sv]
// Package for the converter control and status logic.
// Assumes a byte-wide special-function register port and one system clock.
package adc_ctrl_pkg;

    // Address of the control and status register on the register port.
    localparam logic [7:0] CTRL_STATUS_ADDR = 8'hE8;
    localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

    // Bit positions inside the control and status register.
    localparam int BIT_CONVERTER_ON = 7;
    localparam int BIT_BURST        = 6;
    localparam int BIT_DONE         = 5;
    localparam int BIT_ACTIVE       = 4;
    localparam int BIT_WINDOW       = 3;
    localparam int BIT_LEFT_ALIGN   = 2;
    localparam int BIT_TRIG_HI      = 1;
    localparam int BIT_TRIG_LO      = 0;

    // Start-of-conversion source codes.
    typedef enum logic [1:0] {
        TRIG_SOFTWARE = 2'h0,
        TRIG_TIMER1   = 2'h1,
        TRIG_EXT_PIN  = 2'h2,
        TRIG_TIMER2   = 2'h3
    } trigger_t;

    // Result widths and the padding used when aligning.
    localparam int RESULT_W_DEFAULT = 12;
    localparam int BYTE_W           = 8;

endpackage : adc_ctrl_pkg

// [hw/start_edge_detect.sv]
// Synchroniser and rising edge detector for the external start pin.
// Assumes the pin may change at any time relative to clk.
`timescale 1ns/1ps
module start_edge_detect (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic srst,
    // Raw pin and detected edge.
    input  wire logic pin_raw,
    output logic      rise_pulse
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } edge_state_t;

    edge_state_t state_reg;
    edge_state_t state_next;

    // Two-flop synchroniser, then a registered previous value for edge finding.
    always_comb begin
        state_next      = state_reg;
        state_next.meta = pin_raw;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    // Register the whole state.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // One-cycle pulse on a low to high change of the synchronised pin.
    assign rise_pulse = state_reg.sync & ~state_reg.prev;

    a_edge_one_cycle : assert property (@(posedge clk) disable iff (srst)
        rise_pulse |=> !rise_pulse)
        else $error("Start edge pulse lasted more than one cycle.");

endmodule : start_edge_detect

// [hw/adc_conversion_control.sv]
// Control and status logic for the on-chip analog-to-digital converter.
// Assumes a byte-wide register port with a one-cycle write strobe, an analog
// core that pulses conv_complete when a started conversion finishes, and
// one-cycle timer overflow pulses synchronous to clk.
`timescale 1ns/1ps
// What this block does
// - Enable bit 7 low keeps converter shut down; high makes it accept starts.
// - Done flag bit 5 sets on finished conversion or on a write of 1; a write of 0 clears it.
// - Busy bit 4 reads zero whenever no conversion runs.
// - Writing 0 to busy does nothing; writing 1 starts in software mode.
// - Window flag bit 3 set by hardware or by a write of 1; a write of 0 clears it.
// - Align bit 2 clear gives right-justified result; set gives left-justified.
// - Trigger code 00 starts on busy write; code 01 on timer 1 overflow.
// - Trigger code 10 starts on external pin rising edge; 11 on timer 2.
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int RESULT_W = RESULT_W_DEFAULT
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                srst,
    // Register port.
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_write,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    // Start sources.
    input  wire logic                timer1_overflow,
    input  wire logic                timer2_overflow,
    input  wire logic                external_start_pin,
    // Analog core.
    output logic                     converter_on,
    output logic                     burst_mode_enable,
    output logic                     conv_start,
    input  wire logic                conv_complete,
    input  wire logic [RESULT_W-1:0] conv_data,
    input  wire logic                window_hit,
    // Aligned result bytes.
    output logic      [7:0]          result_high,
    output logic      [7:0]          result_low
);

    // The alignment logic packs the result into two bytes.
    // A result that fits one byte or overflows two cannot be placed, so the width
    // is refused when the design is elaborated.
    if (RESULT_W < BYTE_W + 1 || RESULT_W > 2 * BYTE_W) begin : g_width_check
        $error("RESULT_W must lie between 9 and 16.");
    end

    typedef enum logic {
        CONV_IDLE,
        CONV_RUNNING
    } conv_state_t;

    typedef struct packed {
        logic        conv_on;
        logic        burst;
        logic        done_flag;
        logic        window_flag;
        logic        left_align;
        trigger_t    trig;
        conv_state_t phase;
        logic [7:0]  res_high;
        logic [7:0]  res_low;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    logic             ext_rise;
    logic             reg_hit;
    logic             trig_event;
    logic             start_accept;
    logic             finish;
    logic [2*BYTE_W-1:0] aligned;

    // Synchronised rising edge of the external start pin.
    start_edge_detect u_start_edge (
        .clk        (clk),
        .srst       (srst),
        .pin_raw    (external_start_pin),
        .rise_pulse (ext_rise)
    );

    // Selects the start event of the chosen source.
    function automatic logic pick_trigger(input trigger_t sel, input logic sw_go,
                                          input logic t1, input logic ext, input logic t2);
        case (sel)
            TRIG_SOFTWARE: pick_trigger = sw_go;
            TRIG_TIMER1:   pick_trigger = t1;
            TRIG_EXT_PIN:  pick_trigger = ext;
            TRIG_TIMER2:   pick_trigger = t2;
            default:       pick_trigger = 1'b0;
        endcase
    endfunction : pick_trigger

    // Start decoding; a software start uses the mode already held, not the one being written.
    assign reg_hit      = reg_write && (reg_addr == CTRL_STATUS_ADDR);
    assign trig_event   = pick_trigger(state_reg.trig, reg_hit && reg_wdata[BIT_ACTIVE],
                                       timer1_overflow, ext_rise, timer2_overflow);
    assign start_accept = state_reg.conv_on && (state_reg.phase == CONV_IDLE) && trig_event;
    assign finish       = state_reg.conv_on && (state_reg.phase == CONV_RUNNING) && conv_complete;

    // Places the result right- or left-justified across the two bytes.
    always_comb begin
        aligned = '0;
        if (state_reg.left_align) begin
            aligned = {conv_data, {(2*BYTE_W-RESULT_W){1'b0}}};
        end else begin
            aligned = {{(2*BYTE_W-RESULT_W){1'b0}}, conv_data};
        end
    end

    // Next-state logic: register writes, conversion sequencing and flags.
    always_comb begin
        state_next = state_reg;
        if (reg_hit) begin
            state_next.conv_on     = reg_wdata[BIT_CONVERTER_ON];
            state_next.burst       = reg_wdata[BIT_BURST];
            state_next.done_flag   = reg_wdata[BIT_DONE];
            state_next.window_flag = reg_wdata[BIT_WINDOW];
            state_next.left_align  = reg_wdata[BIT_LEFT_ALIGN];
            state_next.trig        = trigger_t'(reg_wdata[BIT_TRIG_HI:BIT_TRIG_LO]);
        end
        case (state_reg.phase)
            CONV_IDLE: begin
                if (start_accept) begin
                    state_next.phase = CONV_RUNNING;
                end
            end
            CONV_RUNNING: begin
                if (!state_reg.conv_on) begin
                    state_next.phase = CONV_IDLE;
                end else if (finish) begin
                    state_next.phase    = CONV_IDLE;
                    state_next.res_high = aligned[2*BYTE_W-1:BYTE_W];
                    state_next.res_low  = aligned[BYTE_W-1:0];
                end
            end
            default: begin
                state_next.phase = CONV_IDLE;
            end
        endcase
        // Hardware events win over a clearing write in the same cycle.
        if (finish) begin
            state_next.done_flag = 1'b1;
        end
        if (window_hit && state_reg.conv_on) begin
            state_next.window_flag = 1'b1;
        end
    end

    // Register the whole state.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs and read-back of the control and status register.
    assign converter_on      = state_reg.conv_on;
    assign burst_mode_enable = state_reg.burst;
    assign conv_start        = start_accept;
    assign result_high       = state_reg.res_high;
    assign result_low        = state_reg.res_low;
    always_comb begin
        reg_rdata                             = 8'h00;
        reg_rdata[BIT_CONVERTER_ON]           = state_reg.conv_on;
        reg_rdata[BIT_BURST]                  = state_reg.burst;
        reg_rdata[BIT_DONE]                   = state_reg.done_flag;
        reg_rdata[BIT_ACTIVE]                 = (state_reg.phase == CONV_RUNNING);
        reg_rdata[BIT_WINDOW]                 = state_reg.window_flag;
        reg_rdata[BIT_LEFT_ALIGN]             = state_reg.left_align;
        reg_rdata[BIT_TRIG_HI:BIT_TRIG_LO]    = state_reg.trig;
    end

    a_off_no_start : assert property (@(posedge clk) disable iff (srst)
        !state_reg.conv_on |-> !conv_start)
        else $error("Conversion started while converter was off.");

    a_done_sets : assert property (@(posedge clk) disable iff (srst)
        finish |=> state_reg.done_flag && !reg_rdata[BIT_ACTIVE])
        else $error("Done flag not set or busy not cleared on finish.");

    a_done_only_cause : assert property (@(posedge clk) disable iff (srst)
        $rose(state_reg.done_flag) |-> $past(finish) || $past(reg_hit))
        else $error("Done flag rose without a finish or a write.");

    a_busy_idle : assert property (@(posedge clk) disable iff (srst)
        $rose(reg_rdata[BIT_ACTIVE]) |-> $past(conv_start))
        else $error("Busy read high with no conversion running.");

    a_sw_start : assert property (@(posedge clk) disable iff (srst)
        reg_hit && reg_wdata[BIT_ACTIVE] && state_reg.trig == TRIG_SOFTWARE && state_reg.conv_on
        && state_reg.phase == CONV_IDLE |-> conv_start ##1 reg_rdata[BIT_ACTIVE])
        else $error("Software start did not begin a conversion.");

    a_write0_noop : assert property (@(posedge clk) disable iff (srst)
        reg_hit && !reg_wdata[BIT_ACTIVE] && state_reg.trig == TRIG_SOFTWARE |-> !conv_start)
        else $error("Writing zero to busy started a conversion.");

    a_window_sticky : assert property (@(posedge clk) disable iff (srst)
        state_reg.window_flag && !(reg_hit && !reg_wdata[BIT_WINDOW]) |=> state_reg.window_flag)
        else $error("Window flag cleared by hardware.");

    a_align_left : assert property (@(posedge clk) disable iff (srst)
        finish && state_reg.left_align |=> {result_high, result_low} == {$past(conv_data),
        {(2*BYTE_W-RESULT_W){1'b0}}})
        else $error("Left-justified result wrong.");

    a_timer1_start : assert property (@(posedge clk) disable iff (srst)
        timer1_overflow && state_reg.trig == TRIG_TIMER1 && state_reg.conv_on
        && state_reg.phase == CONV_IDLE |-> conv_start)
        else $error("Timer 1 overflow did not start a conversion.");

    a_ext_start : assert property (@(posedge clk) disable iff (srst)
        conv_start && state_reg.trig == TRIG_EXT_PIN |-> ext_rise)
        else $error("Pin-mode start without a pin edge.");

    a_busy_holds : assert property (@(posedge clk) disable iff (srst)
        conv_start || (reg_rdata[BIT_ACTIVE] && !finish && state_reg.conv_on)
        |=> reg_rdata[BIT_ACTIVE])
        else $error("Busy dropped before the conversion finished.");

endmodule : adc_conversion_control

// [verif/analog_core_model.sv]
// Behavioural model of the analog core that stands behind the converter control logic.
// Assumes conv_start is a one-cycle pulse on clk and a latency of at least one cycle.
`timescale 1ns/1ps
module analog_core_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        srst,
    // Start request from the block.
    input  wire logic        conv_start,
    // Settings for the next conversion, chosen by the bench.
    input  wire logic [31:0] latency,
    input  wire logic [11:0] next_data,
    input  wire logic        next_window,
    // Results towards the block.
    output logic             conv_complete,
    output logic [11:0]      conv_data,
    output logic             window_hit
);
    int count;

    // Counts down after a start, then pulses completion with data and window result.
    // Outside the completion cycle the data lines toggle so stale data is never mistaken for valid.
    always @(posedge clk) begin
        conv_complete <= 1'b0;
        window_hit    <= 1'b0;
        conv_data     <= ~conv_data;
        if (srst) begin
            count     <= 0;
            conv_data <= 12'hA5A;
        end else if (conv_start) begin
            count <= int'(latency);
        end else if (count == 1) begin
            count         <= 0;
            conv_complete <= 1'b1;
            conv_data     <= next_data;
            window_hit    <= next_window;
        end else if (count > 1) begin
            count <= count - 1;
        end
    end
endmodule : analog_core_model

// [verif/adc_conversion_control_bench.sv]
// Self-checking bench for the converter control and status logic.
// Assumes the analog core model in its own file and the package of the design.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module adc_conversion_control_bench;
    import adc_ctrl_pkg::*;
    logic        clk = 0, srst = 1, reg_write = 0, t1 = 0, t2 = 0, pin = 0, nwin = 0;
    logic        on, burst, start, done, hit, wsticky, align;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, rh, rl, ctrl;
    logic [11:0] cdata, ndata = 12'h000;
    int          lat = 3, fails = 0, checks = 0, cycles = 0, seed = 75, m, starts = 0;

    // Clock and a cycle ceiling that cuts a hang short.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // Counts the starts that the block hands to the core.
    always @(posedge clk) begin
        if (start === 1'b1) begin
            starts++;
        end
    end

    adc_conversion_control DUT (.clk(clk), .srst(srst), .reg_addr(addr), .reg_write(reg_write),
        .reg_wdata(wdata), .reg_rdata(rdata), .timer1_overflow(t1), .timer2_overflow(t2),
        .external_start_pin(pin), .converter_on(on), .burst_mode_enable(burst), .conv_start(start),
        .conv_complete(done), .conv_data(cdata), .window_hit(hit), .result_high(rh), .result_low(rl));
    analog_core_model core (.clk(clk), .srst(srst), .conv_start(start), .latency(lat), .next_data(ndata),
        .next_window(nwin), .conv_complete(done), .conv_data(cdata), .window_hit(hit));

    // Expected result bytes for a raw value and the alignment setting.
    function automatic logic [15:0] aligned(input logic [11:0] d, input logic l);
        return l ? {d, 4'h0} : {4'h0, d};
    endfunction : aligned

    // Waits one edge and lets its updates settle.
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    // One register write; the strobe is held for exactly one edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr      <= a;
        wdata     <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // Fires one start source: software write, timer 1, external pin or timer 2.
    task automatic fire(input int src);
        if (src == 0) begin
            wr(CTRL_STATUS_ADDR, ctrl | 8'h10);
            return;
        end
        @(posedge clk);
        t1  <= (src == 1);
        pin <= (src == 2);
        t2  <= (src == 3);
        @(posedge clk);
        t1 <= 1'b0;
        t2 <= 1'b0;
        @(posedge clk);
        pin <= 1'b0;
        #1;
    endtask : fire

    // Polls one status bit until it reads the wanted value or the limit runs out.
    task automatic wait_bit(input int b, input logic v, input int lim);
        for (int i = 0; i < lim && rdata[b] !== v; i++) begin
            tick();
        end
    endtask : wait_bit

    // Prints the verdict and ends the run.
    task automatic tally_and_finish;
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence: reset, enable, every trigger source, shutdown and refusals.
    initial begin
        wsticky = 1'b0;
        ctrl    = 8'h00;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        tick();
        `CHK("reset value", CTRL_STATUS_RESET, rdata)
        `CHK("shutdown", 1'b0, on)
        wr(CTRL_STATUS_ADDR, 8'hC0);
        `CHK("burst", 1'b1, burst)
        `CHK("enabled", 1'b1, on)
        for (int n = 0; n < 16; n++) begin
            m     = n % 4;
            align = 1'($random(seed));
            ndata = 12'($random(seed));
            nwin  = 1'($random(seed));
            lat   = 3 + ($random(seed) & 15);
            ctrl  = {4'h8, wsticky, align, 2'(m)};
            wr(CTRL_STATUS_ADDR, ctrl);
            `CHK("flags cleared", ctrl, rdata)
            fire((m + 1) % 4);
            repeat (6) tick();
            `CHK("wrong source", 1'b0, rdata[BIT_ACTIVE])
            fire(m);
            wait_bit(BIT_ACTIVE, 1'b1, 10);
            `CHK("start accepted", 1'b1, rdata[BIT_ACTIVE])
            wait_bit(BIT_DONE, 1'b1, 40);
            `CHK("done flag", 1'b1, rdata[BIT_DONE])
            `CHK("busy released", 1'b0, rdata[BIT_ACTIVE])
            wsticky = wsticky | nwin;
            repeat (3) tick();
            `CHK("window flag", wsticky, rdata[BIT_WINDOW])
            `CHK("result", aligned(ndata, align), {rh, rl})
            `CHK("start count", n + 1, starts)
        end
        // The second write sees software mode held, so a zero busy bit must stay idle.
        repeat (2) wr(CTRL_STATUS_ADDR, 8'h80);
        `CHK("busy write zero", 8'h80, rdata)
        wr(CTRL_STATUS_ADDR, 8'h01);
        fire(1);
        repeat (6) tick();
        `CHK("off ignores start", 1'b0, rdata[BIT_ACTIVE])
        `CHK("no start when off", 16, starts)
        wr(8'hE9, 8'h80);
        `CHK("unmapped write", 8'h01, rdata)
        tally_and_finish();
    end
endmodule : adc_conversion_control_bench
